//--- bench/fmwa_props.sv
`timescale 1ns/1ps
module fmwa_props (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic cmd_data_select,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [17:0] host_data,
  input wire logic host_data_oe,
  input wire logic [17:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic [17:0] data_line
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  // Strobe low two cycles, then released
  sequence wr_pulse_s;
    !write_strobe_n ##1 write_strobe_n;
  endsequence
  sequence rd_drive_s;
    ##[1:3] dev_data_oe;
  endsequence
  a_write_pulse_len:
    assert property ($fell(write_strobe_n) |=> wr_pulse_s)
    else $error("write strobe pulse length wrong");
  a_host_drives_wr:
    assert property (!write_strobe_n |-> host_data_oe)
    else $error("write strobe without host drive");
  a_no_bus_fight:
    assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the data line");
  a_one_strobe_only:
    assert property (!(!write_strobe_n && !read_strobe_n))
    else $error("read and write strobes low together");
  a_stable_payload:
    assert property ($fell(write_strobe_n) |=>
      $stable(host_data) && $stable(cmd_data_select))
    else $error("payload moved during write strobe");
  a_read_answer:
    assert property ($fell(read_strobe_n) |-> rd_drive_s)
    else $error("device did not answer read strobe");
  a_oe_on_param:
    assert property (dev_data_oe |-> cmd_data_select)
    else $error("device drove during command phase");
  a_read_release:
    assert property ($rose(read_strobe_n) |-> ##[0:2] !dev_data_oe)
    else $error("device held the line after read");
endmodule

//--- bench/tb_frame_memory_window_access.sv
`timescale 1ns/1ps
`include "fmwa_consts.svh"
module tb_frame_memory_window_access;
  logic sys_clk_in;
  logic reset_in;
  logic xchg_r;
  logic soft_r;
  logic [7:0] aw_addr_r;
  logic aw_valid_r;
  logic [31:0] w_data_r;
  logic w_valid_r;
  logic b_ready_r;
  logic [7:0] ar_addr_r;
  logic ar_valid_r;
  logic r_ready_r;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [1:0] b_resp;
  logic [1:0] r_resp;
  logic [31:0] r_data;
  logic writing, reading;
  logic [1:0] resp_r;
  logic [31:0] val_r;
  int errors;
  int samples_checked;
  int i;
  fmwa_bus_if fmwa_bus_if_i();
  fmwa_device #(.COLS(240), .ROWS(320)) fmwa_device_i (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .bus(fmwa_bus_if_i),
    .row_col_exchange_in(xchg_r), .soft_reset_in(soft_r),
    .writing_out(writing), .reading_out(reading));
  fmwa_host fmwa_host_i (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .bus(fmwa_bus_if_i),
    .s_axi_awaddr_in(aw_addr_r), .s_axi_awvalid_in(aw_valid_r),
    .s_axi_awready_out(aw_ready), .s_axi_wdata_in(w_data_r),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(w_valid_r),
    .s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp),
    .s_axi_bvalid_out(b_valid), .s_axi_bready_in(b_ready_r),
    .s_axi_araddr_in(ar_addr_r), .s_axi_arvalid_in(ar_valid_r),
    .s_axi_arready_out(ar_ready), .s_axi_rdata_out(r_data),
    .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_valid),
    .s_axi_rready_in(r_ready_r));
  fmwa_props fmwa_props_i (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .cmd_data_select(fmwa_bus_if_i.cmd_data_select),
    .write_strobe_n(fmwa_bus_if_i.write_strobe_n),
    .read_strobe_n(fmwa_bus_if_i.read_strobe_n),
    .host_data(fmwa_bus_if_i.host_data),
    .host_data_oe(fmwa_bus_if_i.host_data_oe),
    .dev_data(fmwa_bus_if_i.dev_data),
    .dev_data_oe(fmwa_bus_if_i.dev_data_oe),
    .data_line(fmwa_bus_if_i.data_line));

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge sys_clk_in);
    aw_addr_r <= a;
    aw_valid_r <= 1'b1;
    w_data_r <= d;
    w_valid_r <= 1'b1;
    b_ready_r <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (aw_ready === 1'b1 && !aw_done) begin
        aw_done = 1'b1;
        aw_valid_r <= 1'b0;
      end
      if (w_ready === 1'b1 && !w_done) begin
        w_done = 1'b1;
        w_valid_r <= 1'b0;
      end
    end while (b_valid !== 1'b1);
    b_ready_r <= 1'b0;
    resp_r = b_resp;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar_done;
    ar_done = 1'b0;
    @(posedge sys_clk_in);
    ar_addr_r <= a;
    ar_valid_r <= 1'b1;
    r_ready_r <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (ar_ready === 1'b1 && !ar_done) begin
        ar_done = 1'b1;
        ar_valid_r <= 1'b0;
      end
    end while (r_valid !== 1'b1);
    r_ready_r <= 1'b0;
    resp_r = r_resp;
    val_r = r_data;
  endtask

  task automatic cmd(input logic [7:0] c);
    wr(`FMWA_REG_CMD, {24'h0, c});
  endtask

  task automatic par(input logic [17:0] d);
    wr(`FMWA_REG_DATA, {14'h0, d});
  endtask

  // Bound bytes go high first; callers keep start <= end
  task automatic bnd(input logic [7:0] c, input logic [15:0] lo,
                     input logic [15:0] hi);
    cmd(c);
    par({10'h0, lo[15:8]});
    par({10'h0, lo[7:0]});
    par({10'h0, hi[15:8]});
    par({10'h0, hi[7:0]});
  endtask

  // Poll status until the link has gone quiet
  task automatic idle();
    do rd(`FMWA_REG_STATUS); while (val_r[0] !== 1'b0);
  endtask

  // One read strobe, wait for the link, fetch the word
  task automatic rdchk(input string n, input logic [17:0] e);
    wr(`FMWA_REG_RD_START, 32'h0);
    idle();
    rd(`FMWA_REG_RD_DATA);
    chk(n, {14'h0, val_r[17:0]}, {14'h0, e});
  endtask

  task automatic hard_reset();
    reset_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    reset_in <= 1'b0;
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    repeat (60000) @(posedge sys_clk_in);
    errors++;
    results();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    {aw_valid_r, w_valid_r, b_ready_r, ar_valid_r, r_ready_r} = 5'h00;
    aw_addr_r = 8'h00;
    ar_addr_r = 8'h00;
    w_data_r = 32'h0;
    xchg_r = 1'b0;
    soft_r = 1'b0;
    reset_in = 1'b1;
    hard_reset();
    rd(8'h20);
    chk("unmapped_rd", {30'h0, resp_r}, {30'h0, `FMWA_RESP_SLVERR});
    wr(8'h24, 32'h0);
    chk("unmapped_wr", {30'h0, resp_r}, {30'h0, `FMWA_RESP_SLVERR});
    bnd(`FMWA_CMD_COL_RANGE, 16'h0002, 16'h0004);
    bnd(`FMWA_CMD_ROW_RANGE, 16'h0005, 16'h0006);
    cmd(`FMWA_CMD_FRAME_WR);
    idle();
    chk("writing", {31'h0, writing}, 32'h1);
    // Seventh pixel wraps onto the window start
    for (i = 0; i < 7; i++) par(18'h3F000 + 18'(i));
    cmd(`FMWA_CMD_FRAME_RD);
    rdchk("dummy", 18'h0);
    chk("reading", {31'h0, reading}, 32'h1);
    chk("wr_ended", {31'h0, writing}, 32'h0);
    for (i = 0; i < 6; i++) rdchk("win_rd",
      (i == 0) ? 18'h3F006 : 18'h3F000 + 18'(i));
    bnd(`FMWA_CMD_COL_RANGE, 16'h0002, 16'h0002);
    cmd(`FMWA_CMD_FRAME_RD);
    rdchk("dummy", 18'h0);
    rdchk("col_rd", 18'h3F006);
    rdchk("col_rd", 18'h3F003);
    cmd(`FMWA_CMD_FRAME_WR);
    par(18'h3F0AA);
    cmd(8'h00);
    par(18'h3F0BB);
    idle();
    chk("stream_end", {31'h0, writing}, 32'h0);
    cmd(`FMWA_CMD_FRAME_RD);
    rdchk("dummy", 18'h0);
    rdchk("reload", 18'h3F0AA);
    rdchk("stopped", 18'h3F003);
    xchg_r <= 1'b1;
    bnd(`FMWA_CMD_COL_RANGE, 16'h0000, 16'h0001);
    bnd(`FMWA_CMD_ROW_RANGE, 16'h0000, 16'h0001);
    cmd(`FMWA_CMD_FRAME_WR);
    for (i = 0; i < 4; i++) par(18'h3E000 + 18'(i));
    bnd(`FMWA_CMD_ROW_RANGE, 16'h0000, 16'h0000);
    cmd(`FMWA_CMD_FRAME_RD);
    rdchk("dummy", 18'h0);
    rdchk("xchg_rd", 18'h3E000);
    rdchk("xchg_rd", 18'h3E002);
    xchg_r <= 1'b0;
    bnd(`FMWA_CMD_COL_RANGE, 16'h0000, 16'h0000);
    bnd(`FMWA_CMD_ROW_RANGE, `FMWA_LIMIT_LONG, 16'h0140);
    cmd(`FMWA_CMD_FRAME_WR);
    par(18'h3D001);
    par(18'h3D002);
    cmd(`FMWA_CMD_FRAME_RD);
    rdchk("dummy", 18'h0);
    rdchk("edge_row", 18'h3D001);
    rdchk("past_limit", 18'h0);
    // Memory survives both resets; defaults restart at the origin
    hard_reset();
    cmd(`FMWA_CMD_FRAME_RD);
    rdchk("dummy", 18'h0);
    rdchk("hw_keep", 18'h3E000);
    rdchk("hw_next", 18'h3E001);
    // Narrow window first so the soft reset has something to undo
    bnd(`FMWA_CMD_COL_RANGE, 16'h0001, 16'h0001);
    idle();
    @(posedge sys_clk_in);
    soft_r <= 1'b1;
    @(posedge sys_clk_in);
    soft_r <= 1'b0;
    cmd(`FMWA_CMD_FRAME_RD);
    rdchk("dummy", 18'h0);
    rdchk("sw_keep", 18'h3E000);
    rdchk("sw_next", 18'h3E001);
    results();
  end
endmodule

//--- core/fmwa_bus_if.sv
`timescale 1ns/1ps
interface fmwa_bus_if;
  logic cmd_data_select;
  logic write_strobe_n;
  logic read_strobe_n;
  logic [17:0] host_data;
  logic host_data_oe;
  logic [17:0] dev_data;
  logic dev_data_oe;
  logic [17:0] data_line;
  // Device wins while it drives; host drives otherwise
  assign data_line = dev_data_oe ? dev_data : host_data;
  modport device (
    input cmd_data_select, write_strobe_n, read_strobe_n, data_line,
    output dev_data, dev_data_oe
  );
  modport host (
    output cmd_data_select, write_strobe_n, read_strobe_n, host_data,
    output host_data_oe,
    input data_line
  );
endinterface

//--- core/fmwa_consts.svh
`ifndef FMWA_CONSTS_SVH
`define FMWA_CONSTS_SVH
`define FMWA_CMD_COL_RANGE 8'h2A
`define FMWA_CMD_ROW_RANGE 8'h2B
`define FMWA_CMD_FRAME_WR 8'h2C
`define FMWA_CMD_FRAME_RD 8'h2E
`define FMWA_BOUND_ZERO 16'h0000
`define FMWA_BOUND_STEP 16'h0001
`define FMWA_LIMIT_LONG 16'h013F
`define FMWA_LIMIT_SHORT 16'h00EF
`define FMWA_PHYS_COLS 240
`define FMWA_PHYS_ROWS 320
`define FMWA_PARAM_FIRST 2'h0
`define FMWA_PARAM_LAST 2'h3
`define FMWA_PIXEL_ZERO 18'h00000
`define FMWA_REG_CMD 8'h00
`define FMWA_REG_DATA 8'h04
`define FMWA_REG_RD_START 8'h08
`define FMWA_REG_RD_DATA 8'h0C
`define FMWA_REG_STATUS 8'h10
`define FMWA_STROBE_CYC 4'h2
`define FMWA_CNT_ONE 4'h1
`define FMWA_RESP_OKAY 2'h0
`define FMWA_RESP_SLVERR 2'h2
`endif

//--- core/fmwa_device.sv
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "fmwa_consts.svh"
// Summary of operation
// - Row command: four bytes, two page bounds
// - Row bounds stored, applied at frame write
// - Host keeps start page not above end
// - Out-of-range row data is discarded
// - Reset defaults for row bounds
// - Frame write takes unlimited 18-bit pixels
// - Frame write reloads pointers to start
// - Each in-range pixel stored; pointers advance on every pixel
// - Any command byte ends the stream
// - Resets leave pixel memory untouched
// - Frame read: dummy word, then pixels
// - Exchange clear: column first, then page
// - Exchange set: page first, then column
// - Column command: bounds, range discard
module fmwa_device
  import fmwa_pkg::*;
#(
  parameter int COLS = `FMWA_PHYS_COLS,
  parameter int ROWS = `FMWA_PHYS_ROWS
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  fmwa_bus_if.device bus,
  input wire logic row_col_exchange_in,
  input wire logic soft_reset_in,
  output logic writing_out,
  output logic reading_out
);
  localparam int ADDR_W = $clog2(COLS * ROWS);

  fmwa_dev_state_t state_r;
  logic [1:0] param_idx_r;
  logic wr_prev_r;
  logic rd_prev_r;
  logic dummy_pending_r;
  fmwa_bound_t first_col_bound_r, last_col_bound_r;
  fmwa_bound_t first_row_bound_r, last_row_bound_r;
  fmwa_bound_t win_c0_r, win_c1_r, win_p0_r, win_p1_r;
  fmwa_bound_t col_r, page_r;
  fmwa_pixel_t dev_data_r;
  logic dev_data_oe_r;
  fmwa_pixel_t mem [0:COLS*ROWS-1];

  logic wr_rise, rd_fall, rd_rise, is_cmd, is_param;
  logic write_pix, read_adv, in_range, open_cmd;
  logic [7:0] bus_byte;
  fmwa_bound_t col_lim, row_lim;
  logic [31:0] next_ptr;
  logic [ADDR_W-1:0] addr;

  function automatic logic [31:0] fmwa_advance(
    input fmwa_bound_t col, page, c0, c1, p0, p1,
    input logic xchg
  );
    fmwa_bound_t nc, np;
    nc = col;
    np = page;
    // Past the last cell the walk restarts at the window start
    if (!xchg) begin
      if (col == c1) begin
        nc = c0;
        np = (page == p1) ? p0 : page + `FMWA_BOUND_STEP;
      end else begin
        nc = col + `FMWA_BOUND_STEP;
      end
    end else begin
      if (page == p1) begin
        np = p0;
        nc = (col == c1) ? c0 : col + `FMWA_BOUND_STEP;
      end else begin
        np = page + `FMWA_BOUND_STEP;
      end
    end
    return {nc, np};
  endfunction

  function automatic logic [ADDR_W-1:0] fmwa_addr(
    input fmwa_bound_t col, page,
    input logic xchg
  );
    logic [31:0] prow, pcol;
    prow = xchg ? {16'h0000, col} : {16'h0000, page};
    pcol = xchg ? {16'h0000, page} : {16'h0000, col};
    return ADDR_W'(prow * COLS + pcol);
  endfunction

  always_comb begin
    wr_rise = !wr_prev_r && bus.write_strobe_n;
    rd_fall = rd_prev_r && !bus.read_strobe_n;
    rd_rise = !rd_prev_r && bus.read_strobe_n;
    bus_byte = bus.data_line[7:0];
    is_cmd = wr_rise && !bus.cmd_data_select;
    is_param = wr_rise && bus.cmd_data_select;
    open_cmd = is_cmd && (bus_byte == `FMWA_CMD_FRAME_WR ||
                          bus_byte == `FMWA_CMD_FRAME_RD);
    col_lim = row_col_exchange_in ? `FMWA_LIMIT_LONG : `FMWA_LIMIT_SHORT;
    row_lim = row_col_exchange_in ? `FMWA_LIMIT_SHORT : `FMWA_LIMIT_LONG;
    in_range = (col_r <= col_lim) && (page_r <= row_lim);
    write_pix = is_param && state_r == DEV_WRITING;
    read_adv = rd_rise && bus.cmd_data_select &&
               state_r == DEV_READING && !dummy_pending_r;
    next_ptr = fmwa_advance(col_r, page_r, win_c0_r, win_c1_r,
                            win_p0_r, win_p1_r, row_col_exchange_in);
    addr = fmwa_addr(col_r, page_r, row_col_exchange_in);
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_prev_r <= 1'b1;
      rd_prev_r <= 1'b1;
    end else begin
      wr_prev_r <= bus.write_strobe_n;
      rd_prev_r <= bus.read_strobe_n;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= DEV_IDLE;
      param_idx_r <= `FMWA_PARAM_FIRST;
    end else if (soft_reset_in) begin
      state_r <= DEV_IDLE;
      param_idx_r <= `FMWA_PARAM_FIRST;
    end else if (is_cmd) begin
      param_idx_r <= `FMWA_PARAM_FIRST;
      case (bus_byte)
        `FMWA_CMD_COL_RANGE: state_r <= DEV_COL_PARAM;
        `FMWA_CMD_ROW_RANGE: state_r <= DEV_ROW_PARAM;
        `FMWA_CMD_FRAME_WR: state_r <= DEV_WRITING;
        `FMWA_CMD_FRAME_RD: state_r <= DEV_READING;
        default: state_r <= DEV_IDLE;
      endcase
    end else if (is_param && (state_r == DEV_COL_PARAM ||
                              state_r == DEV_ROW_PARAM)) begin
      param_idx_r <= param_idx_r + 2'h1;
      if (param_idx_r == `FMWA_PARAM_LAST) begin
        state_r <= DEV_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      first_row_bound_r <= `FMWA_BOUND_ZERO;
      last_row_bound_r <= `FMWA_LIMIT_LONG;
      first_col_bound_r <= `FMWA_BOUND_ZERO;
      last_col_bound_r <= `FMWA_LIMIT_SHORT;
    end else if (soft_reset_in) begin
      first_row_bound_r <= `FMWA_BOUND_ZERO;
      last_row_bound_r <= row_lim;
      first_col_bound_r <= `FMWA_BOUND_ZERO;
      last_col_bound_r <= col_lim;
    end else if (is_param && state_r == DEV_ROW_PARAM) begin
      case (param_idx_r)
        2'h0: first_row_bound_r[15:8] <= bus_byte;
        2'h1: first_row_bound_r[7:0] <= bus_byte;
        2'h2: last_row_bound_r[15:8] <= bus_byte;
        default: last_row_bound_r[7:0] <= bus_byte;
      endcase
    end else if (is_param && state_r == DEV_COL_PARAM) begin
      case (param_idx_r)
        2'h0: first_col_bound_r[15:8] <= bus_byte;
        2'h1: first_col_bound_r[7:0] <= bus_byte;
        2'h2: last_col_bound_r[15:8] <= bus_byte;
        default: last_col_bound_r[7:0] <= bus_byte;
      endcase
    end
  end

  // Stored bounds stay dormant until a stream opens
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      win_c0_r <= `FMWA_BOUND_ZERO;
      win_c1_r <= `FMWA_LIMIT_SHORT;
      win_p0_r <= `FMWA_BOUND_ZERO;
      win_p1_r <= `FMWA_LIMIT_LONG;
      col_r <= `FMWA_BOUND_ZERO;
      page_r <= `FMWA_BOUND_ZERO;
    end else if (open_cmd) begin
      win_c0_r <= first_col_bound_r;
      win_c1_r <= last_col_bound_r;
      win_p0_r <= first_row_bound_r;
      win_p1_r <= last_row_bound_r;
      col_r <= first_col_bound_r;
      page_r <= first_row_bound_r;
    end else if (write_pix || read_adv) begin
      col_r <= next_ptr[31:16];
      page_r <= next_ptr[15:0];
    end
  end

  // No reset: pixel contents survive both resets
  always_ff @(posedge sys_clk_in) begin
    if (write_pix && in_range) begin
      mem[addr] <= bus.data_line;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dummy_pending_r <= 1'b0;
    end else if (open_cmd) begin
      dummy_pending_r <= bus_byte == `FMWA_CMD_FRAME_RD;
    end else if (rd_rise && bus.cmd_data_select) begin
      dummy_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dev_data_r <= `FMWA_PIXEL_ZERO;
      dev_data_oe_r <= 1'b0;
    end else if (rd_fall && bus.cmd_data_select) begin
      dev_data_oe_r <= 1'b1;
      if (state_r == DEV_READING && !dummy_pending_r && in_range) begin
        dev_data_r <= mem[addr];
      end else begin
        dev_data_r <= `FMWA_PIXEL_ZERO;
      end
    end else if (rd_rise) begin
      dev_data_oe_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      writing_out <= 1'b0;
      reading_out <= 1'b0;
    end else begin
      writing_out <= state_r == DEV_WRITING;
      reading_out <= state_r == DEV_READING;
    end
  end

  assign bus.dev_data = dev_data_r;
  assign bus.dev_data_oe = dev_data_oe_r;
endmodule

//--- core/fmwa_host.sv
`timescale 1ns/1ps
`include "fmwa_consts.svh"
module fmwa_host
  import fmwa_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  fmwa_bus_if.host bus,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  fmwa_host_state_t state_r;
  logic [3:0] cnt_r;
  logic aw_held_r, w_held_r;
  logic [7:0] waddr_r;
  logic [17:0] wdata_r;
  fmwa_pixel_t rd_data_r;
  logic cds_r, wr_n_r, rd_n_r, oe_r;
  fmwa_pixel_t hdata_r;
  logic launch, mapped_w, busy;

  // Strobes are unused: every register takes the low 18 bits of the word
  always_comb begin
    busy = state_r != HOST_IDLE;
    launch = aw_held_r && w_held_r && !s_axi_bvalid_out && !busy;
    mapped_w = waddr_r == `FMWA_REG_CMD || waddr_r == `FMWA_REG_DATA ||
               waddr_r == `FMWA_REG_RD_START;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= `FMWA_PIXEL_ZERO;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `FMWA_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_r <= 1'b1;
        waddr_r <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata_in[17:0];
        s_axi_wready_out <= 1'b0;
      end
      // Busy link stalls the response, which back-pressures software
      if (launch) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= mapped_w ? `FMWA_RESP_OKAY : `FMWA_RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `FMWA_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= `FMWA_RESP_OKAY;
      case (s_axi_araddr_in)
        `FMWA_REG_RD_DATA: s_axi_rdata_out <= {14'h0000, rd_data_r};
        `FMWA_REG_STATUS: s_axi_rdata_out <= {31'h00000000, busy};
        default: begin
          s_axi_rdata_out <= 32'h00000000;
          s_axi_rresp_out <= `FMWA_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // Each phase lasts a fixed count so the device sees every edge
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= HOST_IDLE;
      cnt_r <= `FMWA_CNT_ONE;
      cds_r <= 1'b1;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      oe_r <= 1'b0;
      hdata_r <= `FMWA_PIXEL_ZERO;
      rd_data_r <= `FMWA_PIXEL_ZERO;
    end else begin
      case (state_r)
        HOST_IDLE: begin
          cnt_r <= `FMWA_STROBE_CYC;
          if (launch && mapped_w) begin
            if (waddr_r == `FMWA_REG_RD_START) begin
              cds_r <= 1'b1;
              rd_n_r <= 1'b0;
              state_r <= HOST_RD_LOW;
            end else begin
              cds_r <= waddr_r == `FMWA_REG_DATA;
              hdata_r <= wdata_r;
              oe_r <= 1'b1;
              wr_n_r <= 1'b0;
              state_r <= HOST_WR_LOW;
            end
          end
        end
        HOST_WR_LOW: begin
          cnt_r <= cnt_r - `FMWA_CNT_ONE;
          if (cnt_r == `FMWA_CNT_ONE) begin
            wr_n_r <= 1'b1;
            cnt_r <= `FMWA_STROBE_CYC;
            state_r <= HOST_WR_HIGH;
          end
        end
        HOST_WR_HIGH: begin
          cnt_r <= cnt_r - `FMWA_CNT_ONE;
          if (cnt_r == `FMWA_CNT_ONE) begin
            oe_r <= 1'b0;
            state_r <= HOST_IDLE;
          end
        end
        HOST_RD_LOW: begin
          cnt_r <= cnt_r - `FMWA_CNT_ONE;
          if (cnt_r == `FMWA_CNT_ONE) begin
            rd_data_r <= bus.data_line;
            rd_n_r <= 1'b1;
            cnt_r <= `FMWA_STROBE_CYC;
            state_r <= HOST_RD_HIGH;
          end
        end
        HOST_RD_HIGH: begin
          cnt_r <= cnt_r - `FMWA_CNT_ONE;
          if (cnt_r == `FMWA_CNT_ONE) begin
            state_r <= HOST_IDLE;
          end
        end
        default: state_r <= HOST_IDLE;
      endcase
    end
  end

  assign bus.cmd_data_select = cds_r;
  assign bus.write_strobe_n = wr_n_r;
  assign bus.read_strobe_n = rd_n_r;
  assign bus.host_data = hdata_r;
  assign bus.host_data_oe = oe_r;
endmodule

//--- core/fmwa_pkg.sv
package fmwa_pkg;
  typedef logic [15:0] fmwa_bound_t;
  typedef logic [17:0] fmwa_pixel_t;
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_COL_PARAM, DEV_ROW_PARAM, DEV_WRITING, DEV_READING
  } fmwa_dev_state_t;
  typedef enum logic [2:0] {
    HOST_IDLE, HOST_WR_LOW, HOST_WR_HIGH, HOST_RD_LOW, HOST_RD_HIGH
  } fmwa_host_state_t;
endpackage
